// *** shared/current_dac_defines.vh ***
// constants for the serial-controlled current setting block
`ifndef CURRENT_DAC_DEFINES_VH
`define CURRENT_DAC_DEFINES_VH
`define REG_CHAN0_ADDR 8'hF8
`define REG_RESET_VAL 8'h00
`define SIGN_BIT 7
`define MAG_MSB 6
`define ADDR_BASE 8'h20
`define ADDR_STRAP_STEP 8'h40
`define CHAN_COUNT_DEFAULT 4
`endif

// *** logic/setting_regs.v ***
// small register store holding one setting byte per current channel
`timescale 1ns/1ps
`default_nettype none
`include "current_dac_defines.vh"
module setting_regs #(
  parameter CHANS = `CHAN_COUNT_DEFAULT
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_wr_en,
  input wire [1:0] i_wr_idx,
  input wire [7:0] i_wr_data,
  input wire [1:0] i_rd_idx,
  output reg [7:0] o_rd_data,
  output wire [8*CHANS-1:0] o_all
);
  genvar g;
  // one register per channel, cleared at reset; each has a single driver
  generate
    for (g = 0; g < CHANS; g = g + 1) begin : g_ch
      reg [7:0] slot_q;
      always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          slot_q <= `REG_RESET_VAL;
        end else if (i_wr_en && i_wr_idx == g) begin
          slot_q <= i_wr_data;
        end
      end
      assign o_all[8*g+7:8*g] = slot_q;
    end
  endgenerate
  // registered read port; an unbuilt channel reads as zero
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_idx < CHANS) begin
      o_rd_data <= o_all[8*i_rd_idx +: 8];
    end else begin
      o_rd_data <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** logic/i2c_current_dac_control.v ***
// serial-bus slave that stores sign/magnitude current settings per channel
//
// Behaviour
// - slave address byte 20h/60h/A0h/E0h chosen by the two strap pins.
// - each channel offers 127 sink and 127 source nonzero settings.
// - setting byte is sign in bit 7, magnitude in bits 6..0.
// - sign 0 means sink, sign 1 means source.
// - zero magnitude gives zero current whatever the sign.
// - all setting registers clear to zero at reset.
// - channel zero setting lives at register address F8h.
// - parameter picks two or four channels; two-channel build has 0 and 1.
// - data falling while clock high is a start, begins a transfer.
// - data rising while clock high is a stop, ends the transfer.
// - repeated start is accepted without a preceding stop.
// - incoming bits are captured on the clock rising edge.
// - outgoing bits change at the clock falling edge.
// - ninth bit is acknowledge, receiver pulls data low.
// - bus idle between stop and start with both lines high.
// - address mismatch means ignore everything until next start.
// - second byte of a write is the register address.
`timescale 1ns/1ps
`default_nettype none
`include "current_dac_defines.vh"
module i2c_current_dac_control #(
  parameter CHANS = `CHAN_COUNT_DEFAULT
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  input wire i_addr_strap_low,
  input wire i_addr_strap_high,
  output reg [7:0] o_current_chan_zero,
  output reg [7:0] o_current_chan_one,
  output reg [7:0] o_current_chan_two,
  output reg [7:0] o_current_chan_three,
  output reg [3:0] o_chan_source,
  output reg [3:0] o_chan_active
);
  // byte engine states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_REG = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_READ = 3'h4;
  localparam ST_IGNORE = 3'h5;

  // maps a register address to a channel index and validity
  function [2:0] reg_decode;
    input [7:0] addr;
    reg [7:0] off;
    begin
      off = addr - `REG_CHAN0_ADDR;
      reg_decode = {(addr >= `REG_CHAN0_ADDR) && (off < CHANS), off[1:0]};
    end
  endfunction

  // pin synchroniser stages, the third stage of each bus pin keeps history
  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;
  reg str_m_q, str_s_q;
  reg strh_m_q, strh_s_q;
  // byte engine state
  reg [2:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [1:0] ptr_q;
  reg ptr_ok_q;
  reg ack_phase_q;
  reg do_ack_q;
  // write port towards the setting store
  reg wr_en_q;
  reg [7:0] wr_data_q;
  reg [1:0] wr_idx_q;
  wire [7:0] rd_data;
  wire [8*CHANS-1:0] all_regs;
  // bus event wires; the edge, start and stop strobes are each true for one system clock
  wire scl_rise, scl_fall;
  wire start_ev, stop_ev;
  wire byte_done;
  wire [7:0] my_addr;
  wire [2:0] dec;

  // scl synchroniser plus a history stage for edge finding, idle level high
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      scl_m_q <= i_scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
    end
  end

  // sda synchroniser, same depth as scl so the two keep their order
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sda_m_q <= i_sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // address strap synchronisers
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      str_m_q <= 1'b0;
      str_s_q <= 1'b0;
      strh_m_q <= 1'b0;
      strh_s_q <= 1'b0;
    end else begin
      str_m_q <= i_addr_strap_low;
      str_s_q <= str_m_q;
      strh_m_q <= i_addr_strap_high;
      strh_s_q <= strh_m_q;
    end
  end

  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_ev = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_ev = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
  // strap selects one of four address bytes
  assign my_addr = `ADDR_BASE + (`ADDR_STRAP_STEP * {6'h00, strh_s_q, str_s_q});
  assign dec = reg_decode(shift_q);
  // eighth bit of the current byte has gone by
  assign byte_done = (bit_q == 4'h8);

  // byte engine: shifts on rising edges, acts at falling edges
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 2'h0;
      ptr_ok_q <= 1'b0;
      ack_phase_q <= 1'b0;
      do_ack_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_idx_q <= 2'h0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      wr_en_q <= 1'b0;
      if (start_ev) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        ack_phase_q <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (stop_ev) begin
        state_q <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
        if (scl_rise && !ack_phase_q) begin
          shift_q <= {shift_q[6:0], sda_s_q};
          bit_q <= bit_q + 4'h1;
        end else if (scl_rise && ack_phase_q && state_q == ST_READ && bit_q == 4'h8) begin
          // master ack or nack after read byte; nack ends driving
          if (sda_s_q) begin
            state_q <= ST_IGNORE;
          end
        end else if (scl_fall) begin
          if (ack_phase_q) begin
            // end of ninth bit: release or start next read byte
            ack_phase_q <= 1'b0;
            bit_q <= 4'h0;
            if (state_q == ST_READ && do_ack_q) begin
              // each read byte reloads the addressed setting; bit count restarts at zero
              o_sda_oe <= !rd_data[7];
              o_sda_out <= 1'b0;
              tx_q <= {rd_data[6:0], 1'b1};
              do_ack_q <= 1'b0;
            end else if (state_q == ST_READ) begin
              o_sda_oe <= 1'b0;
            end else begin
              o_sda_oe <= 1'b0;
            end
          end else if (state_q == ST_READ && !byte_done) begin
            o_sda_oe <= !tx_q[7];
            o_sda_out <= 1'b0;
            tx_q <= {tx_q[6:0], 1'b1};
          end else if (byte_done) begin
            ack_phase_q <= 1'b1;
            case (state_q)
              ST_ADDR: begin
                // only the own address is acked; a read loads the pointed setting
                if (shift_q[7:1] == my_addr[7:1]) begin
                  o_sda_oe <= 1'b1;
                  o_sda_out <= 1'b0;
                  if (shift_q[0]) begin
                    state_q <= ST_READ;
                    tx_q <= rd_data;
                    do_ack_q <= 1'b1;
                  end else begin
                    state_q <= ST_REG;
                  end
                end else begin
                  state_q <= ST_IGNORE;
                  o_sda_oe <= 1'b0;
                end
              end
              ST_REG: begin
                ptr_q <= dec[1:0];
                ptr_ok_q <= dec[2];
                o_sda_oe <= 1'b1;
                o_sda_out <= 1'b0;
                state_q <= ST_DATA;
              end
              ST_DATA: begin
                wr_en_q <= ptr_ok_q;
                wr_data_q <= shift_q;
                wr_idx_q <= ptr_q;
                o_sda_oe <= 1'b1;
                o_sda_out <= 1'b0;
              end
              ST_READ: begin
                // read byte done: release for master ack bit
                o_sda_oe <= 1'b0;
                bit_q <= 4'h8;
                do_ack_q <= 1'b0;
              end
              default: begin
                state_q <= ST_IGNORE;
              end
            endcase
          end
        end else if (scl_rise && ack_phase_q && state_q == ST_READ) begin
          do_ack_q <= !sda_s_q;
        end
      end
      if (!start_ev && state_q == ST_READ && ack_phase_q && scl_rise && bit_q == 4'h8) begin
        do_ack_q <= !sda_s_q;
      end
    end
  end

  setting_regs #(
    .CHANS(CHANS)
  ) u_regs (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_en(wr_en_q),
    .i_wr_idx(wr_idx_q),
    .i_wr_data(wr_data_q),
    .i_rd_idx(ptr_q),
    .o_rd_data(rd_data),
    .o_all(all_regs)
  );

  // registered channel setting bytes; unbuilt channels read zero
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_current_chan_zero <= `REG_RESET_VAL;
      o_current_chan_one <= `REG_RESET_VAL;
      o_current_chan_two <= `REG_RESET_VAL;
      o_current_chan_three <= `REG_RESET_VAL;
    end else begin
      o_current_chan_zero <= all_regs[7:0];
      o_current_chan_one <= all_regs[15:8];
      o_current_chan_two <= (CHANS > 2) ? all_regs[8*(CHANS-1)-1 -: 8] : 8'h00;
      o_current_chan_three <= (CHANS > 2) ? all_regs[8*CHANS-1 -: 8] : 8'h00;
    end
  end

  // per-channel direction and activity flags
  integer k;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chan_source <= 4'h0;
      o_chan_active <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (k < CHANS) begin
          // zero magnitude means no current and no direction
          o_chan_active[k] <= |all_regs[8*k+`MAG_MSB -: 7];
          o_chan_source[k] <= all_regs[8*k+`SIGN_BIT] && (|all_regs[8*k+`MAG_MSB -: 7]);
        end else begin
          o_chan_active[k] <= 1'b0;
          o_chan_source[k] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/i2c_master_model.sv ***
// bus master model driving the serial clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // idle bus, both lines high
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // start or repeated start, data falls with clock high
  task automatic start();
    @(posedge i_sys_clk);
    o_sda_low <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_sda_low <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_scl <= 1'b0;
  endtask
  // stop, data rises with clock high
  task automatic stop();
    @(posedge i_sys_clk);
    o_sda_low <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    o_scl <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_sda_low <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  // nine bits msb first, ninth is ack
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      @(posedge i_sys_clk);
      o_sda_low <= ~tx[i]; // data moves with clock low, released early
      repeat (3) @(posedge i_sys_clk);
      o_scl <= 1'b1; // every clock pulse is ours
      repeat (4) @(posedge i_sys_clk);
      rx[i] = i_sda;
      o_scl <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/i2c_current_dac_control_sva.sv ***
// property checker for the current setting block
`timescale 1ns/1ps
`default_nettype none
module dac_ctl_chk #(parameter int CHANS = 4) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [7:0] o_current_chan_zero,
  input wire logic [7:0] o_current_chan_one,
  input wire logic [7:0] o_current_chan_two,
  input wire logic [7:0] o_current_chan_three,
  input wire logic [3:0] o_chan_source,
  input wire logic [3:0] o_chan_active
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  reset_clear_a: assert property ($fell(i_rst) |-> {o_current_chan_zero, o_current_chan_one,
    o_current_chan_two, o_current_chan_three, o_chan_source, o_chan_active} == 40'h0)
    else $error("outputs not clear after reset");
  mag_active_a: assert property ($changed(o_current_chan_zero) |->
    ##[0:2] o_chan_active[0] == |o_current_chan_zero[6:0]) else $error("active flag wrong");
  sign_source_a: assert property ($changed(o_current_chan_zero) |-> ##[0:2]
    o_chan_source[0] == (o_current_chan_zero[7] & |o_current_chan_zero[6:0]))
    else $error("source flag wrong");
  chan_one_a: assert property ($changed(o_current_chan_one) |->
    ##[0:2] o_chan_active[1] == |o_current_chan_one[6:0]) else $error("channel one flag wrong");
  open_drain_a: assert property (o_sda_oe |-> o_sda_out == 1'b0)
    else $error("data driven high");
  ack_update_a: assert property ($changed(o_current_chan_zero) |-> o_sda_oe)
    else $error("setting changed outside ack");
  edge_drive_a: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("data drive changed with clock high");
  ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe[*6])
    else $error("drive too short");
  cover property ($fell(o_sda_oe));
  cover property ($rose(o_chan_source[0]));
  cover property ($changed(o_current_chan_three));
endmodule
bind i2c_current_dac_control dac_ctl_chk #(.CHANS(CHANS)) chk (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_current_chan_zero(o_current_chan_zero), .o_current_chan_one(o_current_chan_one),
  .o_current_chan_two(o_current_chan_two), .o_current_chan_three(o_current_chan_three),
  .o_chan_source(o_chan_source), .o_chan_active(o_chan_active));
`default_nettype wire

// *** tb/i2c_current_dac_control_test.sv ***
// testbench for the serial-controlled current setting block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module i2c_current_dac_control_test;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic a_lo = 1'b0;
  logic a_hi = 1'b0;
  wire scl, sda_low, sda_out, sda_oe;
  wire sda = ~(sda_low | (sda_oe & ~sda_out)); // pulled-up wired line
  wire [7:0] ch [4];
  wire [3:0] src, act;
  int err_total = 0;
  int checks = 0;
  logic [8:0] rx;
  logic [7:0] vals [5] = '{8'h80, 8'h00, 8'h7F, 8'hFF, 8'h01};
  i2c_current_dac_control #(.CHANS(4)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_addr_strap_low(a_lo), .i_addr_strap_high(a_hi), .o_current_chan_zero(ch[0]),
    .o_current_chan_one(ch[1]), .o_current_chan_two(ch[2]), .o_current_chan_three(ch[3]),
    .o_chan_source(src), .o_chan_active(act));
  i2c_master_model m (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // 40 MHz clock
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // write one setting; nak is the expected address ack bit
  task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
      input logic nak);
    m.start();
    m.xfer({dev, 1'b1}, rx);
    `CHK(rx[0], nak) // address match
    m.xfer({ra, 1'b1}, rx);
    m.xfer({d, 1'b1}, rx);
    m.stop();
  endtask
  // set pointer, repeated start, read one byte with nack
  task automatic rd(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] exp);
    m.start();
    m.xfer({dev, 1'b1}, rx);
    m.xfer({ra, 1'b1}, rx);
    m.start();
    m.xfer({dev | 8'h01, 1'b1}, rx);
    m.xfer(9'h1FF, rx);
    m.stop();
    `CHK(rx[8:1], exp) // readback
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    `CHK({ch[0], ch[1], ch[2], ch[3], src, act}, 40'h0) // cleared
    for (int k = 0; k < 4; k++) begin
      {a_hi, a_lo} <= k[1:0];
      wr(8'h22, 8'hF8, 8'h11, 1'b1); // foreign address ignored
      wr(8'h20 + 8'h40 * k[7:0], 8'hF8 + k[7:0], 8'h81 + k[7:0], 1'b0);
      `CHK(ch[k], 8'h81 + k[7:0]) // stored
      `CHK({src[k], act[k]}, 2'h3) // source on
      rd(8'h20 + 8'h40 * k[7:0], 8'hF8 + k[7:0], 8'h81 + k[7:0]);
    end
    `CHK(ch[0], 8'h81) // untouched by ignored writes
    foreach (vals[i]) begin
      wr(8'hE0, 8'hF8, vals[i], 1'b0);
      `CHK(ch[0], vals[i]) // sign and magnitude
      `CHK({src[0], act[0]}, {vals[i][7] & |vals[i][6:0], |vals[i][6:0]})
    end
    // two-byte read: master acks the first byte, both carry channel zero
    m.start();
    m.xfer({8'hE1, 1'b1}, rx);
    `CHK(rx[0], 1'b0) // read address acked
    m.xfer(9'h1FE, rx);
    `CHK(rx[8:1], vals[4]) // first byte
    m.xfer(9'h1FF, rx);
    m.stop();
    `CHK(rx[8:1], vals[4]) // same setting after master ack
    wr(8'hE0, 8'hFC, 8'h55, 1'b0);
    `CHK({ch[0], ch[1], ch[2], ch[3]}, 32'h01828384) // unmapped write dropped
    i_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    `CHK({ch[0], ch[1], ch[2], ch[3], src, act}, 40'h0) // cleared again
    close_out();
  end
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
